// ==== hdl/e1fc_channel_ctl.sv ====
// receive framers, error toggle, per-channel gain/loopback and signalling store
`timescale 1ns/1ps
`include "e1fc_map.svh"
module e1fc_channel_ctl #(
   parameter int unsigned ERR_HOLD_CYC = `E1FC_ERR_HOLD_CYC,
   parameter int unsigned CRC_SRCH_CYC = `E1FC_CRC_SRCH_CYC,
   parameter int unsigned CRC_WIN_CYC = `E1FC_CRC_WIN_CYC,
   parameter int unsigned SIG_HOLD_CYC = `E1FC_SIG_HOLD_CYC,
   parameter int unsigned DEB_TICK_CYC = `E1FC_DEB_TICK_CYC
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // decoded line side pins
   input wire logic line_clk,
   input wire logic line_data,
   input wire logic inversion_coding_select,
   // control stream words from host
   input wire logic ctl_wr_en,
   input wire logic ctl_wr_stream,
   input wire logic [4:0] ctl_wr_chan,
   input wire logic [7:0] ctl_wr_data,
   // transmit payload from host
   input wire logic tx_valid,
   input wire e1fc_pkg::e1fc_slot_byte_t tx_in,
   output logic tx_line_valid,
   output e1fc_pkg::e1fc_slot_byte_t tx_line,
   // received payload to host
   output logic rx_out_valid,
   output e1fc_pkg::e1fc_slot_byte_t rx_out,
   // crc checker and maintenance
   input wire logic crc_block_err,
   input wire logic maint_enable,
   // signalling read port
   input wire logic [4:0] sig_rd_chan,
   output logic [3:0] sig_rd_data,
   // status
   output logic [7:0] master_status_one
);

   function automatic logic [7:0] apply_gain(input logic [7:0] b, input logic [2:0] code,
                                             input logic bypass, input logic inv);
      logic [7:0] x;
      logic [7:0] m;
      logic [7:0] sub;
      logic [7:0] msk;
      msk = inv ? `E1FC_INV_MASK : 8'h00;
      x = b ^ msk;
      m = {1'b0, x[6:0]};
      sub = 8'(code) * `E1FC_GAIN_STEP;
      if (code == `E1FC_GAIN_PLUS1) begin
         m = m + `E1FC_GAIN_STEP;
         if (m[7]) begin
            m = 8'h7F;
         end
      end else if (m < sub) begin
         m = 8'h00;
      end else begin
         m = m - sub;
      end
      apply_gain = bypass ? b : ({x[7], m[6:0]} ^ msk);
   endfunction

   // pin synchronisers: line clock, line data, inversion select
   logic [2:0] pin_s1_ff;
   logic [2:0] pin_s2_ff;
   logic lclk_d_ff;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_ff <= 3'h0;
         pin_s2_ff <= 3'h0;
         lclk_d_ff <= 1'b0;
      end else begin
         pin_s1_ff <= {line_clk, line_data, inversion_coding_select};
         pin_s2_ff <= pin_s1_ff;
         lclk_d_ff <= pin_s2_ff[2];
      end
   end
   wire bit_en = pin_s2_ff[2] & ~lclk_d_ff;
   wire rx_bit = pin_s2_ff[1];
   wire inv_sel = pin_s2_ff[0];

   // bit and slot position
   e1fc_pkg::e1fc_frm_state_t frm_ff;
   logic [7:0] rx_sh_ff;
   logic [7:0] bitpos_ff;
   logic byte_stb_ff;
   logic fas_frame_ff;
   logic reframe_ff;
   wire [6:0] nxt_win = {rx_sh_ff[5:0], rx_bit};
   wire search_hit = bit_en & (frm_ff == e1fc_pkg::FR_SEARCH) & (nxt_win == `E1FC_FAS_WORD);
   wire [4:0] slot = bitpos_ff[7:3];
   wire slot0_stb = byte_stb_ff & (slot == `E1FC_SLOT_TS0);
   wire slot16_stb = byte_stb_ff & (slot == `E1FC_SLOT_TS16);
   wire slot31_stb = byte_stb_ff & (slot == `E1FC_SLOT_LAST);
   wire fsync = (frm_ff == e1fc_pkg::FR_SYNC);
   wire fas_ok = (rx_sh_ff[6:0] == `E1FC_FAS_WORD);
   wire fas_err = slot0_stb & fsync & fas_frame_ff & ~fas_ok;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rx_sh_ff <= 8'h00;
         bitpos_ff <= 8'h00;
         byte_stb_ff <= 1'b0;
      end else begin
         byte_stb_ff <= bit_en & (search_hit | (bitpos_ff[2:0] == 3'h6));
         if (bit_en) begin
            rx_sh_ff <= {rx_sh_ff[6:0], rx_bit};
            bitpos_ff <= search_hit ? 8'h07 : bitpos_ff + 8'h01;
         end
      end
   end

   // alternate-frame parity: alignment word frame versus the other
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         fas_frame_ff <= 1'b0;
      end else if (search_hit) begin
         fas_frame_ff <= 1'b1;
      end else if (slot31_stb) begin
         fas_frame_ff <= ~fas_frame_ff;
      end
   end

   // frame alignment framer
   logic [1:0] fas_loss_ff;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         frm_ff <= e1fc_pkg::FR_SEARCH;
         fas_loss_ff <= 2'h0;
      end else if (reframe_ff) begin
         frm_ff <= e1fc_pkg::FR_SEARCH;
         fas_loss_ff <= 2'h0;
      end else if (search_hit) begin
         frm_ff <= e1fc_pkg::FR_NFAS;
      end else if (slot0_stb) begin
         case (frm_ff)
            e1fc_pkg::FR_NFAS: begin
               if (!fas_frame_ff) begin
                  frm_ff <= rx_sh_ff[`E1FC_NAS_CHK_BIT] ? e1fc_pkg::FR_FAS2
                                                        : e1fc_pkg::FR_SEARCH;
               end
            end
            e1fc_pkg::FR_FAS2: begin
               if (fas_frame_ff) begin
                  frm_ff <= fas_ok ? e1fc_pkg::FR_SYNC : e1fc_pkg::FR_SEARCH;
                  fas_loss_ff <= 2'h0;
               end
            end
            e1fc_pkg::FR_SYNC: begin
               if (fas_frame_ff && fas_ok) begin
                  fas_loss_ff <= 2'h0;
               end else if (fas_err && fas_loss_ff == `E1FC_FAS_LOSS) begin
                  frm_ff <= e1fc_pkg::FR_SEARCH;
                  fas_loss_ff <= 2'h0;
               end else if (fas_err) begin
                  fas_loss_ff <= fas_loss_ff + 2'h1;
               end
            end
            e1fc_pkg::FR_SEARCH: begin
               frm_ff <= e1fc_pkg::FR_SEARCH;
            end
            default: begin
               frm_ff <= e1fc_pkg::FR_SEARCH;
            end
         endcase
      end
   end

   // alignment error toggle with rate limit
   logic [3:0] err16_ff;
   logic err_pend_ff;
   logic err_tgl_ff;
   logic [27:0] err_hold_ff;
   wire err_fire = err_pend_ff & (err_hold_ff == 28'h0);
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         err16_ff <= 4'h0;
         err_pend_ff <= 1'b0;
         err_tgl_ff <= 1'b0;
         err_hold_ff <= 28'h0;
      end else begin
         if (fas_err) begin
            err16_ff <= err16_ff + 4'h1;
         end
         if (fas_err && err16_ff == `E1FC_ERR_WRAP) begin
            err_pend_ff <= 1'b1;
         end else if (err_fire) begin
            err_pend_ff <= 1'b0;
         end
         if (err_fire) begin
            err_tgl_ff <= ~err_tgl_ff;
            err_hold_ff <= 28'(ERR_HOLD_CYC - 1);
         end else if (err_hold_ff != 28'h0) begin
            err_hold_ff <= err_hold_ff - 28'h1;
         end
      end
   end

   // multiframe framer
   logic mf_sync_ff;
   logic [3:0] mf_frame_ff;
   logic [1:0] mf_err_ff;
   wire nib_zero = (rx_sh_ff[7:4] == 4'h0);
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mf_sync_ff <= 1'b0;
         mf_frame_ff <= 4'h0;
         mf_err_ff <= 2'h0;
      end else if (!fsync) begin
         mf_sync_ff <= 1'b0;
         mf_err_ff <= 2'h0;
      end else if (slot16_stb && !mf_sync_ff) begin
         if (nib_zero) begin
            mf_sync_ff <= 1'b1;
            mf_frame_ff <= 4'h0;
            mf_err_ff <= 2'h0;
         end
      end else if (slot16_stb && mf_frame_ff == 4'h0) begin
         if (nib_zero) begin
            mf_err_ff <= 2'h0;
         end else if (mf_err_ff == `E1FC_MF_LOSS) begin
            mf_sync_ff <= 1'b0;
         end else begin
            mf_err_ff <= mf_err_ff + 2'h1;
         end
      end else if (slot31_stb && mf_sync_ff) begin
         mf_frame_ff <= mf_frame_ff + 4'h1;
      end
   end

   // crc multiframe framer
   logic [4:0] crc_sh_ff;
   logic crc_armed_ff;
   logic [2:0] crc_gap_ff;
   logic crc_sync_ff;
   wire [5:0] crc_patt = {crc_sh_ff, rx_sh_ff[`E1FC_CRC_BIT]};
   wire nas_stb = slot0_stb & fsync & ~fas_frame_ff;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         crc_sh_ff <= 5'h00;
         crc_armed_ff <= 1'b0;
         crc_gap_ff <= 3'h0;
         crc_sync_ff <= 1'b0;
      end else if (!fsync) begin
         crc_armed_ff <= 1'b0;
         crc_sync_ff <= 1'b0;
      end else if (nas_stb) begin
         crc_sh_ff <= crc_patt[4:0];
         crc_gap_ff <= crc_gap_ff + 3'h1;
         if (!crc_sync_ff && crc_patt == `E1FC_CRC_MFAS) begin
            crc_sync_ff <= crc_armed_ff & (crc_gap_ff == `E1FC_CRC_MFAS_GAP);
            crc_armed_ff <= 1'b1;
            crc_gap_ff <= 3'h0;
         end
      end
   end

   // maintenance reframe: search timeout and error rate
   logic [27:0] crc_srch_ff;
   logic [27:0] crc_win_ff;
   logic [9:0] crc_errs_ff;
   wire srch_expired = (crc_srch_ff == 28'(CRC_SRCH_CYC - 1));
   wire rate_exceeded = crc_sync_ff & crc_block_err & (crc_errs_ff == `E1FC_CRC_ERR_LIMIT);
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         crc_srch_ff <= 28'h0;
         crc_win_ff <= 28'h0;
         crc_errs_ff <= 10'h000;
         reframe_ff <= 1'b0;
      end else begin
         reframe_ff <= maint_enable & fsync & (srch_expired | rate_exceeded);
         crc_srch_ff <= (!fsync || crc_sync_ff || srch_expired) ? 28'h0 : crc_srch_ff + 28'h1;
         if (crc_win_ff == 28'(CRC_WIN_CYC - 1) || !crc_sync_ff) begin
            crc_win_ff <= 28'h0;
            crc_errs_ff <= 10'h000;
         end else begin
            crc_win_ff <= crc_win_ff + 28'h1;
            if (crc_block_err && crc_errs_ff != `E1FC_CRC_ERR_LIMIT) begin
               crc_errs_ff <= crc_errs_ff + 10'h001;
            end
         end
      end
   end

   // control stream words
   e1fc_pkg::e1fc_ctl_word_t ctl_ram [32];
   logic [7:0] receive_master_control_ff;
   logic [7:0] fas_word_ff;
   logic [7:0] nfas_word_ff;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 32; i++) begin
            ctl_ram[i] <= e1fc_pkg::e1fc_ctl_word_t'(`E1FC_CTL_RESET);
         end
      end else if (ctl_wr_en && !ctl_wr_stream && ctl_wr_chan != `E1FC_RECEIVE_MASTER_CONTROL_CHAN) begin
         ctl_ram[ctl_wr_chan + 5'h01] <= e1fc_pkg::e1fc_ctl_word_t'(ctl_wr_data);
      end
   end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         receive_master_control_ff <= `E1FC_RECEIVE_MASTER_CONTROL_RESET;
         fas_word_ff <= `E1FC_WORD_RESET;
         nfas_word_ff <= `E1FC_WORD_RESET;
      end else if (ctl_wr_en) begin
         if (!ctl_wr_stream && ctl_wr_chan == `E1FC_RECEIVE_MASTER_CONTROL_CHAN) begin
            receive_master_control_ff <= ctl_wr_data;
         end
         if (ctl_wr_stream && ctl_wr_chan == `E1FC_FAS_CHAN) begin
            fas_word_ff <= ctl_wr_data;
         end
         if (ctl_wr_stream && ctl_wr_chan == `E1FC_NFAS_CHAN) begin
            nfas_word_ff <= ctl_wr_data;
         end
      end
   end
   wire [3:0] ndb = receive_master_control_ff[3:0];

   // transmit multiplexer
   logic [7:0] tx_ram [32];
   logic tx_fas_ff;
   e1fc_pkg::e1fc_ctl_word_t tx_w;
   assign tx_w = ctl_ram[tx_in.chan];
   always_ff @(posedge clk_sys) begin
      if (tx_valid) begin
         tx_ram[tx_in.chan] <= tx_in.data;
      end
   end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tx_fas_ff <= 1'b1;
         tx_line_valid <= 1'b0;
         tx_line <= '0;
      end else begin
         tx_line_valid <= tx_valid;
         if (tx_valid) begin
            tx_line.chan <= tx_in.chan;
            if (tx_in.chan == `E1FC_SLOT_TS0) begin
               tx_fas_ff <= ~tx_fas_ff;
               tx_line.data <= tx_fas_ff ? fas_word_ff : nfas_word_ff;
            end else if (tx_in.chan == `E1FC_SLOT_TS16) begin
               tx_line.data <= tx_in.data;
            end else begin
               tx_line.data <= apply_gain(tx_in.data, tx_w.tx_gain_code, tx_w.data_chan,
                                          inv_sel);
            end
         end
      end
   end

   // receive payload with loopback and gain
   e1fc_pkg::e1fc_ctl_word_t rx_w;
   logic [7:0] rx_src;
   logic payload;
   always_comb begin
      rx_w = ctl_ram[slot];
      payload = (slot != `E1FC_SLOT_TS0) && (slot != `E1FC_SLOT_TS16);
      rx_src = rx_sh_ff;
      if (slot == `E1FC_SLOT_TS16 && receive_master_control_ff[`E1FC_RECEIVE_MASTER_CONTROL_TS16_LOOPBACK_BIT]) begin
         rx_src = tx_ram[`E1FC_SLOT_TS16];
      end else if (payload && rx_w.loop) begin
         rx_src = tx_ram[slot];
      end
   end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rx_out_valid <= 1'b0;
         rx_out <= '0;
      end else begin
         rx_out_valid <= byte_stb_ff & fsync;
         if (byte_stb_ff && fsync) begin
            rx_out.chan <= slot;
            rx_out.data <= payload ? apply_gain(rx_src, rx_w.rx_gain_code, rx_w.data_chan,
                                                inv_sel) : rx_src;
         end
      end
   end

   // signalling store: debounce tick and loss-of-sync hold
   logic [27:0] deb_cnt_ff;
   logic [27:0] sig_hold_ff;
   logic sig_flush_ff;
   wire deb_tick = (deb_cnt_ff == 28'(DEB_TICK_CYC - 1));
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         deb_cnt_ff <= 28'h0;
         sig_hold_ff <= 28'h0;
         sig_flush_ff <= 1'b0;
      end else begin
         deb_cnt_ff <= deb_tick ? 28'h0 : deb_cnt_ff + 28'h1;
         if (fsync) begin
            sig_hold_ff <= 28'h0;
            sig_flush_ff <= 1'b0;
         end else if (ndb == 4'hF || sig_hold_ff == 28'(SIG_HOLD_CYC - 1)) begin
            sig_flush_ff <= 1'b1;
         end else begin
            sig_hold_ff <= sig_hold_ff + 28'h1;
         end
      end
   end

   wire sig_stb = slot16_stb & fsync & mf_sync_ff & (mf_frame_ff != 4'h0);
   logic [127:0] sig_all;
   for (genvar g = 0; g < 32; g++) begin : g_sig
      logic [3:0] acc_ff;
      logic [3:0] cand_ff;
      logic [2:0] age_ff;
      wire [3:0] nib = (g < 16) ? rx_sh_ff[7:4] : rx_sh_ff[3:0];
      wire hit = sig_stb & (5'(g) == {g >= 16, mf_frame_ff});
      wire [3:0] diff = (nib ^ acc_ff) & ~ndb;
      wire pend = (((cand_ff ^ acc_ff) & ~ndb) != 4'h0);
      wire adv = deb_tick & fsync & pend;
      wire take = adv & (age_ff == `E1FC_DEB_ACCEPT - 3'h1);
      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            acc_ff <= 4'hF;
            cand_ff <= 4'hF;
            age_ff <= 3'h0;
         end else if (sig_flush_ff) begin
            acc_ff <= 4'hF;
            cand_ff <= 4'hF;
            age_ff <= 3'h0;
         end else if (hit && diff == 4'h0) begin
            acc_ff <= (acc_ff & ~ndb) | (nib & ndb);
            cand_ff <= nib;
            age_ff <= 3'h0;
         end else if (hit && ((nib ^ cand_ff) & ~ndb) != 4'h0) begin
            acc_ff <= (acc_ff & ~ndb) | (nib & ndb);
            cand_ff <= nib;
            age_ff <= 3'h0;
         end else begin
            if (hit) begin
               acc_ff <= (acc_ff & ~ndb) | (nib & ndb);
            end
            if (take) begin
               acc_ff <= (acc_ff & ndb) | (cand_ff & ~ndb) | (hit ? (nib & ndb) : 4'h0);
               age_ff <= 3'h0;
            end else if (adv) begin
               age_ff <= age_ff + 3'h1;
            end
         end
      end
      assign sig_all[g*4 +: 4] = acc_ff;
   end

   // signalling read and status
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sig_rd_data <= 4'hF;
         master_status_one <= 8'h00;
      end else begin
         sig_rd_data <= sig_all[{sig_rd_chan, 2'b00} +: 4];
         master_status_one <= 8'h00;
         master_status_one[`E1FC_MS1_ERR_BIT] <= err_tgl_ff;
         master_status_one[2:0] <= {crc_sync_ff, mf_sync_ff, fsync};
      end
   end

endmodule // e1fc_channel_ctl

// ==== hdl/e1fc_map.svh ====
// constants for the trunk receive alignment and channel control block
// Functional notes
// - Count errored alignment words; toggle status bit 5 every sixteen errors.
// - Error toggle bit changes at most once per 128 ms.
// - Alignment word is 0011011, present in alternate frames, 4000 per second.
// - Payload channels pass a gain stage set by control bits 5..0 unless bit 7 is set; slots 0 and 16 skip it.
// - Control word on channel n governs data channel n+1.
// - Received ABCD bits are stored per timeslot, valid only while frame-synchronized.
// - On sync loss with debounce active, stored bits hold 6.0 ms first.
// - Debounced signalling change is accepted after 6.0 to 8.0 ms.
// - Payload uses timeslots 1-15 and 17-31; 0 is sync, 16 signalling.
// - Host gives alignment word on stream one ch16, non-alignment on ch17.
// - Find alignment word, check next non-alignment bit 2, then alignment gives sync.
// - Multiframe search only under frame sync; four zeros in slot 16 nibble.
// - Multiframe sync lost after two errored patterns or frame sync loss.
// - CRC framer starts under frame sync; second CRC pattern declares sync.
// - With maintenance on, reframe if no CRC sync in 8 ms or >914 errors/s.
// - Control bit 7 marks pure data: no inversion coding, no gain.
// - Master word bit 6 loops slot 16 under frame sync; control bit 6 loops each payload slot.
// - Master word bits 3..0 disable debounce of bits A..D individually.
`ifndef E1FC_MAP_SVH
`define E1FC_MAP_SVH
`define E1FC_CLK_KHZ 250000
`define E1FC_FAS_WORD 7'h1B
`define E1FC_FAS_LOSS 2'h2
`define E1FC_ERR_WRAP 4'hF
`define E1FC_ERR_HOLD_MS 128
`define E1FC_ERR_HOLD_CYC (`E1FC_ERR_HOLD_MS * `E1FC_CLK_KHZ)
`define E1FC_CRC_SRCH_MS 8
`define E1FC_CRC_SRCH_CYC (`E1FC_CRC_SRCH_MS * `E1FC_CLK_KHZ)
`define E1FC_CRC_WIN_MS 1000
`define E1FC_CRC_WIN_CYC (`E1FC_CRC_WIN_MS * `E1FC_CLK_KHZ)
`define E1FC_CRC_ERR_LIMIT 10'h392
`define E1FC_CRC_MFAS 6'h0B
`define E1FC_CRC_MFAS_GAP 3'h7
`define E1FC_SIG_HOLD_US 6000
`define E1FC_SIG_HOLD_CYC (`E1FC_SIG_HOLD_US * `E1FC_CLK_KHZ / 1000)
`define E1FC_DEB_TICK_US 2000
`define E1FC_DEB_TICK_CYC (`E1FC_DEB_TICK_US * `E1FC_CLK_KHZ / 1000)
`define E1FC_DEB_ACCEPT 3'h4
`define E1FC_MF_LOSS 2'h1
`define E1FC_INV_MASK 8'h55
`define E1FC_GAIN_STEP 8'h03
`define E1FC_GAIN_PLUS1 3'h7
`define E1FC_SLOT_TS0 5'h00
`define E1FC_SLOT_TS16 5'h10
`define E1FC_SLOT_LAST 5'h1F
`define E1FC_RECEIVE_MASTER_CONTROL_CHAN 5'h0F
`define E1FC_FAS_CHAN 5'h10
`define E1FC_NFAS_CHAN 5'h11
`define E1FC_RECEIVE_MASTER_CONTROL_TS16_LOOPBACK_BIT 6
`define E1FC_MS1_ERR_BIT 5
`define E1FC_NAS_CHK_BIT 6
`define E1FC_CRC_BIT 7
`define E1FC_RECEIVE_MASTER_CONTROL_RESET 8'hB0
`define E1FC_CTL_RESET 8'h00
`define E1FC_WORD_RESET 8'hFF
`endif

// ==== hdl/e1fc_pkg.sv ====
// types for the trunk receive alignment and channel control block
package e1fc_pkg;
   typedef enum logic [3:0] {
      FR_SEARCH = 4'b0001,
      FR_NFAS = 4'b0010,
      FR_FAS2 = 4'b0100,
      FR_SYNC = 4'b1000
   } e1fc_frm_state_t;

   typedef struct packed {
      logic data_chan;
      logic loop;
      logic [2:0] rx_gain_code;
      logic [2:0] tx_gain_code;
   } e1fc_ctl_word_t;

   typedef struct packed {
      logic [4:0] chan;
      logic [7:0] data;
   } e1fc_slot_byte_t;
endpackage

// ==== verif/e1fc_channel_ctl_chk.sv ====
// assertion checker for the trunk alignment and channel control block
`timescale 1ns/1ps
module e1fc_channel_ctl_chk #(
   parameter int unsigned ERR_HOLD_CYC = 1000,
   parameter int unsigned CRC_SRCH_CYC = 2000
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // transmit side
   input wire logic tx_valid,
   input wire e1fc_pkg::e1fc_slot_byte_t tx_in,
   input wire logic tx_line_valid,
   input wire e1fc_pkg::e1fc_slot_byte_t tx_line,
   // receive side and status
   input wire logic rx_out_valid,
   input wire logic maint_enable,
   input wire logic [7:0] master_status_one
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   logic last_err_ff;
   int unsigned hold_cnt_ff;
   int unsigned srch_cnt_ff;
   // cycles since the error toggle last moved
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         last_err_ff <= 1'b0;
         hold_cnt_ff <= ERR_HOLD_CYC;
      end else begin
         last_err_ff <= master_status_one[5];
         if (master_status_one[5] != last_err_ff)
            hold_cnt_ff <= 0;
         else if (hold_cnt_ff < ERR_HOLD_CYC)
            hold_cnt_ff <= hold_cnt_ff + 1;
      end
   end
   // cycles of frame sync without crc sync while maintenance is on
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n)
         srch_cnt_ff <= 0;
      else if (maint_enable && master_status_one[0] && !master_status_one[2])
         srch_cnt_ff <= srch_cnt_ff + 1;
      else
         srch_cnt_ff <= 0;
   end
   chk_tx_answer: assert property (tx_valid |=> tx_line_valid)
      else $error("transmit byte not answered next cycle");
   chk_ts16_pass: assert property (tx_valid && tx_in.chan == 5'h10 |=> tx_line == $past(tx_in))
      else $error("signalling slot altered on transmit");
   chk_rx_sync_only: assert property (rx_out_valid |-> master_status_one[0] || $past(master_status_one[0]))
      else $error("received byte delivered without frame sync");
   chk_mf_after_frame: assert property ($rose(master_status_one[1]) |-> master_status_one[0])
      else $error("multiframe sync without frame sync");
   chk_mf_drop: assert property ($fell(master_status_one[0]) |-> ##[0:2] !master_status_one[1])
      else $error("multiframe sync kept after frame loss");
   chk_crc_after_frame: assert property ($rose(master_status_one[2]) |-> master_status_one[0])
      else $error("crc sync without frame sync");
   chk_err_spacing: assert property (master_status_one[5] != last_err_ff |-> hold_cnt_ff >= ERR_HOLD_CYC - 1)
      else $error("error toggle moved inside hold time");
   chk_reframe_bound: assert property (srch_cnt_ff <= CRC_SRCH_CYC + 8)
      else $error("no reframe after crc search time");
endmodule // e1fc_channel_ctl_chk
bind e1fc_channel_ctl e1fc_channel_ctl_chk #(.ERR_HOLD_CYC(ERR_HOLD_CYC), .CRC_SRCH_CYC(CRC_SRCH_CYC))
   chk_i (.clk_sys(clk_sys), .rst_n(rst_n), .tx_valid(tx_valid), .tx_in(tx_in),
   .tx_line_valid(tx_line_valid), .tx_line(tx_line), .rx_out_valid(rx_out_valid),
   .maint_enable(maint_enable), .master_status_one(master_status_one));

// ==== verif/e1fc_line_model.sv ====
// far-end trunk model sending framed line bits
`timescale 1ns/1ps
module e1fc_line_model (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // fault control
   input wire logic fas_err,
   // line pins
   output logic line_clk,
   output logic line_data
);
   logic [1:0] ph_ff;
   logic [7:0] pos_ff;
   logic [3:0] frm_ff;
   logic [1:0] ecnt_ff;
   logic [7:0] cur;
   // crc framing bit per odd frame: 001011 then two spare zeros
   localparam logic [7:0] CRC_SEQ = 8'h34;
   // two of every three alignment words errored while fas_err
   always_comb begin
      if (pos_ff[7:3] == 5'h00 && frm_ff[0])
         cur = {CRC_SEQ[frm_ff[3:1]], 7'h40};
      else if (pos_ff[7:3] == 5'h00)
         cur = (fas_err && ecnt_ff != 2'h2) ? 8'h1A : 8'h1B;
      else if (pos_ff[7:3] == 5'h10)
         cur = (frm_ff == 4'h0) ? 8'h0B : 8'h5A;
      else
         cur = {3'h6, pos_ff[7:3]};
   end
   assign line_clk = ph_ff[1];
   assign line_data = cur[3'h7 - pos_ff[2:0]];
   // bit advances as the line clock falls
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ph_ff <= 2'h0;
         pos_ff <= 8'h00;
         frm_ff <= 4'h0;
         ecnt_ff <= 2'h0;
      end else begin
         ph_ff <= ph_ff + 2'h1;
         if (ph_ff == 2'h3)
            pos_ff <= pos_ff + 8'h01;
         if (ph_ff == 2'h3 && pos_ff == 8'hFF) begin
            frm_ff <= frm_ff + 4'h1;
            if (!frm_ff[0] && fas_err)
               ecnt_ff <= (ecnt_ff == 2'h2) ? 2'h0 : ecnt_ff + 2'h1;
         end
      end
   end
endmodule // e1fc_line_model

// ==== verif/tb.sv ====
// self-checking bench for the trunk alignment and channel control block
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
   $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb;
   logic clk_sys = 1'b0;
   logic rst_n, line_clk, line_data, fas_err, ctl_wr_en, ctl_wr_stream, tx_valid;
   logic tx_line_valid, rx_out_valid, maint_enable, inv_pin, crc_block_err;
   logic [4:0] ctl_wr_chan, sig_rd_chan;
   logic [7:0] ctl_wr_data, master_status_one;
   logic [3:0] sig_rd_data;
   e1fc_pkg::e1fc_slot_byte_t tx_in, tx_line, rx_out;
   int bad_count = 0;
   int num_checks = 0;
   always #2 clk_sys = ~clk_sys;
   e1fc_line_model e1fc_line_model_i (.clk_sys(clk_sys), .rst_n(rst_n), .fas_err(fas_err),
      .line_clk(line_clk), .line_data(line_data));
   e1fc_channel_ctl #(.ERR_HOLD_CYC(1000), .CRC_SRCH_CYC(2000), .CRC_WIN_CYC(4000),
      .SIG_HOLD_CYC(300), .DEB_TICK_CYC(100)) e1fc_channel_ctl_i (
      .clk_sys(clk_sys), .rst_n(rst_n), .line_clk(line_clk), .line_data(line_data),
      .inversion_coding_select(inv_pin), .ctl_wr_en(ctl_wr_en), .ctl_wr_stream(ctl_wr_stream),
      .ctl_wr_chan(ctl_wr_chan), .ctl_wr_data(ctl_wr_data), .tx_valid(tx_valid), .tx_in(tx_in),
      .tx_line_valid(tx_line_valid), .tx_line(tx_line), .rx_out_valid(rx_out_valid),
      .rx_out(rx_out), .crc_block_err(crc_block_err), .maint_enable(maint_enable),
      .sig_rd_chan(sig_rd_chan), .sig_rd_data(sig_rd_data),
      .master_status_one(master_status_one));
   task automatic conclude();
      $display("checks=%0d mismatches=%0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic wr(input logic s, input logic [4:0] c, input logic [7:0] d);
      @(posedge clk_sys);
      ctl_wr_en <= 1'b1;
      ctl_wr_stream <= s;
      ctl_wr_chan <= c;
      ctl_wr_data <= d;
      @(posedge clk_sys);
      ctl_wr_en <= 1'b0;
   endtask
   task automatic tx(input logic [4:0] c, input logic [7:0] d, input logic [7:0] e);
      @(posedge clk_sys);
      tx_valid <= 1'b1;
      tx_in <= {c, d};
      @(posedge clk_sys);
      tx_valid <= 1'b0;
      #1;
      `CHK(tx_line_valid, 1'b1)
      `CHK(tx_line, {c, e})
   endtask
   task automatic rx(input logic [4:0] c, input logic [7:0] e);
      int n;
      n = 0;
      while (!(rx_out_valid === 1'b1 && rx_out.chan === c) && n < 2000) begin
         @(posedge clk_sys);
         #1 n++;
      end
      if (n >= 2000) begin
         bad_count++;
         conclude();
      end else
         `CHK(rx_out.data, e)
   endtask
   task automatic wait_st(input int b, input logic v, input int lim);
      int n;
      n = 0;
      while (master_status_one[b] !== v && n < lim) begin
         @(posedge clk_sys);
         #1 n++;
      end
      if (n >= lim) begin
         bad_count++;
         conclude();
      end else
         `CHK(master_status_one[b], v)
   endtask
   initial begin
      rst_n = 1'b0;
      fas_err = 1'b0;
      ctl_wr_en = 1'b0;
      ctl_wr_stream = 1'b0;
      ctl_wr_chan = 5'h00;
      ctl_wr_data = 8'h00;
      tx_valid = 1'b0;
      tx_in = 13'h0000;
      maint_enable = 1'b0;
      inv_pin = 1'b0;
      crc_block_err = 1'b0;
      sig_rd_chan = 5'h01;
      repeat (8) @(posedge clk_sys);
      `CHK(master_status_one, 8'h00)
      `CHK(sig_rd_data, 4'hF)
      rst_n <= 1'b1;
      wr(1'b0, 5'h0F, 8'hB0);
      wr(1'b1, 5'h10, 8'h1B);
      wr(1'b1, 5'h11, 8'h40);
      tx(5'h00, 8'h00, 8'h1B);
      tx(5'h00, 8'h00, 8'h40);
      tx(5'h10, 8'h77, 8'h77);
      wr(1'b0, 5'h04, 8'h0A);
      tx(5'h05, 8'h45, 8'h3F);
      wr(1'b0, 5'h04, 8'h8A);
      tx(5'h05, 8'h45, 8'h45);
      wr(1'b0, 5'h04, 8'h0A);
      wr(1'b0, 5'h05, 8'h40);
      tx(5'h06, 8'h33, 8'h33);
      inv_pin <= 1'b1;
      repeat (2) @(posedge clk_sys);
      tx(5'h05, 8'h45, 8'h5F);
      inv_pin <= 1'b0;
      wait_st(0, 1'b1, 8000);
      wait_st(1, 1'b1, 20000);
      rx(5'h05, 8'hC2);
      rx(5'h06, 8'h33);
      rx(5'h07, 8'hC7);
      wr(1'b0, 5'h0F, 8'hF0);
      repeat (2) @(posedge clk_sys);
      rx(5'h10, 8'h77);
      fas_err <= 1'b1;
      wait_st(5, 1'b1, 60000);
      `CHK(master_status_one[0], 1'b1)
      `CHK(master_status_one[2], 1'b1)
      fas_err <= 1'b0;
      maint_enable <= 1'b1;
      crc_block_err <= 1'b1;
      wait_st(0, 1'b0, 2400);
      crc_block_err <= 1'b0;
      `CHK(sig_rd_data, 4'h5)
      sig_rd_chan <= 5'h11;
      repeat (2) @(posedge clk_sys);
      #1;
      `CHK(sig_rd_data, 4'hA)
      repeat (400) @(posedge clk_sys);
      #1;
      `CHK(sig_rd_data, 4'hF)
      conclude();
   end
endmodule // tb
